// file: hw/uecc_pkg.sv
// Purpose: Constants for the endpoint-0 handshake control block
// Assumes: Avalon-MM 32-bit register access, one word per register
// Notes:   Offsets are byte addresses (index times four)
package uecc_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [9:0] EP0_CTRL_INDEX  = 10'h0ea;
  localparam logic [11:0] EP0_CTRL_ADDR  = 12'h3a8;
  localparam logic [11:0] EP0_STAT_ADDR  = 12'h3ac;
  localparam logic [11:0] EP0_EVT_ADDR   = 12'h3b0;
  localparam logic [7:0]  EP0_CTRL_RESET = 8'h00;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int TOGGLE_BIT   = 7;
  localparam int STALL_BIT    = 6;
  localparam int TX_EN_BIT    = 5;
  localparam int RX_EN_BIT    = 4;
  localparam int COUNT_MSB    = 3;
  localparam int TXDONE_BIT   = 0;
  localparam int RXDONE_BIT   = 1;

  // ----------------------------------------------------------------
  // Token and answer codes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    UECC_TOK_OUT   = 2'b00,
    UECC_TOK_IN    = 2'b01,
    UECC_TOK_SETUP = 2'b11,
    UECC_TOK_SOF   = 2'b10
  } uecc_token_t;

  typedef enum logic [2:0] {
    UECC_ANS_NONE  = 3'b000,
    UECC_ANS_DATA0 = 3'b001,
    UECC_ANS_DATA1 = 3'b010,
    UECC_ANS_NAK   = 3'b011,
    UECC_ANS_STALL = 3'b100,
    UECC_ANS_ACCEPT = 3'b101
  } uecc_answer_t;

endpackage : uecc_pkg

// file: hw/uecc_decide.sv
// Purpose: Combinational answer decision for one endpoint-0 token
// Assumes: Inputs stable while token_valid_i is high
// Notes:   Pure logic, registered by the caller
`timescale 1ns/1ps
module uecc_decide (
  input  wire logic                  token_valid_i,
  input  wire uecc_pkg::uecc_token_t token_kind_i,
  input  wire logic                  toggle_i,
  input  wire logic                  stall_i,
  input  wire logic                  tx_enable_i,
  input  wire logic                  rx_enable_i,
  input  wire logic                  tx_done_i,
  input  wire logic                  rx_done_i,
  output      uecc_pkg::uecc_answer_t answer_o
);
  import uecc_pkg::*;

  always_comb begin
    answer_o = UECC_ANS_NONE;
    if (token_valid_i) begin
      case (token_kind_i)
        UECC_TOK_IN: begin
          if (stall_i) begin
            answer_o = UECC_ANS_STALL;
          end else if (!tx_enable_i || tx_done_i) begin
            answer_o = UECC_ANS_NAK;
          // send only enabled; toggle picks pid
          end else begin
            answer_o = toggle_i ? UECC_ANS_DATA1 : UECC_ANS_DATA0;
          end
        end
        UECC_TOK_OUT: begin
          if (stall_i) begin
            answer_o = UECC_ANS_STALL;
          end else if (!rx_enable_i || rx_done_i) begin
            answer_o = UECC_ANS_NAK;
          end else begin
            answer_o = UECC_ANS_ACCEPT;
          end
        end
        default: answer_o = UECC_ANS_NONE;
      endcase
    end
  end

endmodule : uecc_decide

// file: hw/uecc_top.sv
// Purpose: Endpoint-0 handshake control with Avalon-MM register access
// Assumes: Token inputs come from a serial engine on the same clock
// Notes:   Done flags are inputs owned by the status logic elsewhere
//
// Function
// - Toggle bit picks DATA0 when zero, DATA1 when one for next IN data.
// - Force-stall set makes every endpoint-0 IN or OUT token get STALL.
// - Receiving a SETUP token clears the force-stall bit in hardware.
// - IN data is sent only while the transmit enable is set.
// - IN tokens get NAK if transmit enable is zero or tx-done set.
// - OUT data is accepted only while the receive enable is set.
// - OUT tokens get NAK if receive enable is zero or rx-done set.
// - Four low bits hold the byte count of the next transmission.
// - Reset clears toggle, stall, both enables and the byte count.
//
// Implementation choice: the Avalon-MM slave port.
`timescale 1ns/1ps
module uecc_top (
  input  wire logic                   mclk_i,
  input  wire logic                   reset_i,
  // Avalon-MM slave
  input  wire logic [11:0]            avs_address_i,
  input  wire logic                   avs_read_i,
  input  wire logic                   avs_write_i,
  input  wire logic [31:0]            avs_writedata_i,
  input  wire logic [3:0]             avs_byteenable_i,
  output      logic [31:0]            avs_readdata_o,
  output      logic                   avs_waitrequest_o,
  output      logic [1:0]             avs_response_o,
  // Token side
  input  wire logic                   token_valid_i,
  input  wire uecc_pkg::uecc_token_t  token_kind_i,
  input  wire logic                   ep0_tx_done_flag_i,
  input  wire logic                   ep0_rx_done_flag_i,
  output      logic                   answer_valid_o,
  output      uecc_pkg::uecc_answer_t answer_code_o,
  output      logic [3:0]             answer_length_o,
  output      logic                   ep0_data_toggle_o,
  output      logic                   ep0_force_stall_o
);
  import uecc_pkg::*;

  // ----------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------
  logic       ep0_data_toggle_reg;
  logic       ep0_force_stall_reg;
  logic       ep0_tx_enable_reg;
  logic       ep0_rx_enable_reg;
  logic [3:0] ep0_tx_byte_count_reg;
  logic [1:0] event_seen_reg;
  logic       ack_reg;
  logic [31:0] rdata_reg;
  logic       answer_valid_reg;
  uecc_answer_t answer_code_reg;
  logic [3:0] answer_length_reg;
  uecc_answer_t answer_next;

  logic access;
  logic xfer;
  logic wr_ctrl;
  logic wr_evt;
  logic setup_seen;

  assign access     = (avs_read_i || avs_write_i) && !ack_reg;
  // Writes land at the edge where waitrequest is seen low
  assign xfer       = (avs_read_i || avs_write_i) && ack_reg;
  assign wr_ctrl    = xfer && avs_write_i && avs_byteenable_i[0]
                      && (avs_address_i == EP0_CTRL_ADDR);
  assign wr_evt     = xfer && avs_write_i && avs_byteenable_i[0]
                      && (avs_address_i == EP0_EVT_ADDR);
  assign setup_seen = token_valid_i && (token_kind_i == UECC_TOK_SETUP);

  // ----------------------------------------------------------------
  // Bus handshake: one wait cycle, then answer
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= access;
    end
  end

  assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !ack_reg;
  assign avs_response_o    = 2'b00;
  assign avs_readdata_o    = rdata_reg;

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      rdata_reg <= 32'h0000_0000;
    end else if (access && avs_read_i) begin
      case (avs_address_i)
        EP0_CTRL_ADDR: rdata_reg <= {24'h00_0000, ep0_data_toggle_reg,
                                     ep0_force_stall_reg, ep0_tx_enable_reg,
                                     ep0_rx_enable_reg,
                                     ep0_tx_byte_count_reg};
        EP0_STAT_ADDR: rdata_reg <= {30'h0000_0000, ep0_rx_done_flag_i,
                                     ep0_tx_done_flag_i};
        EP0_EVT_ADDR:  rdata_reg <= {30'h0000_0000, event_seen_reg};
        default:       rdata_reg <= 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  // reset clears fields; toggle only by software
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      ep0_data_toggle_reg   <= EP0_CTRL_RESET[TOGGLE_BIT];
      ep0_tx_enable_reg     <= EP0_CTRL_RESET[TX_EN_BIT];
      ep0_rx_enable_reg     <= EP0_CTRL_RESET[RX_EN_BIT];
      ep0_tx_byte_count_reg <= EP0_CTRL_RESET[COUNT_MSB:0];
    end else if (wr_ctrl) begin
      ep0_data_toggle_reg   <= avs_writedata_i[TOGGLE_BIT];
      ep0_tx_enable_reg     <= avs_writedata_i[TX_EN_BIT];
      ep0_rx_enable_reg     <= avs_writedata_i[RX_EN_BIT];
      ep0_tx_byte_count_reg <= avs_writedata_i[COUNT_MSB:0];
    end
  end

  // setup clears stall, wins over write
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      ep0_force_stall_reg <= EP0_CTRL_RESET[STALL_BIT];
    end else if (setup_seen) begin
      ep0_force_stall_reg <= 1'b0;
    end else if (wr_ctrl) begin
      ep0_force_stall_reg <= avs_writedata_i[STALL_BIT];
    end
  end

  // Sticky token log: bit0 stall sent, bit1 setup seen; write one clears
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      event_seen_reg <= 2'b00;
    end else begin
      event_seen_reg[0] <= (answer_next == UECC_ANS_STALL)
                           || (event_seen_reg[0]
                               && !(wr_evt && avs_writedata_i[0]));
      event_seen_reg[1] <= setup_seen
                           || (event_seen_reg[1]
                               && !(wr_evt && avs_writedata_i[1]));
    end
  end

  // ----------------------------------------------------------------
  // Token answer
  // ----------------------------------------------------------------
  uecc_decide u_decide (
    .token_valid_i (token_valid_i),
    .token_kind_i  (token_kind_i),
    .toggle_i      (ep0_data_toggle_reg),
    .stall_i       (ep0_force_stall_reg),
    .tx_enable_i   (ep0_tx_enable_reg),
    .rx_enable_i   (ep0_rx_enable_reg),
    .tx_done_i     (ep0_tx_done_flag_i),
    .rx_done_i     (ep0_rx_done_flag_i),
    .answer_o      (answer_next)
  );

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      answer_valid_reg  <= 1'b0;
      answer_code_reg   <= UECC_ANS_NONE;
      answer_length_reg <= 4'h0;
    end else begin
      answer_valid_reg  <= (answer_next != UECC_ANS_NONE);
      answer_code_reg   <= answer_next;
      answer_length_reg <= ((answer_next == UECC_ANS_DATA0)
                            || (answer_next == UECC_ANS_DATA1))
                           ? ep0_tx_byte_count_reg : 4'h0;
    end
  end

  assign answer_valid_o    = answer_valid_reg;
  assign answer_code_o     = answer_code_reg;
  assign answer_length_o   = answer_length_reg;
  assign ep0_data_toggle_o = ep0_data_toggle_reg;
  assign ep0_force_stall_o = ep0_force_stall_reg;

endmodule : uecc_top

// file: test/uecc_properties.sv
// Purpose: Port assertions for the endpoint-0 handshake block
// Assumes: Bound to uecc_top, one clock domain
// Notes:   Only toggle and stall are visible as register levels
`timescale 1ns/1ps
module uecc_properties import uecc_pkg::*; (
  input wire logic         mclk_i,
  input wire logic         reset_i,
  input wire logic         avs_write_i,
  input wire logic         token_valid_i,
  input wire uecc_token_t  token_kind_i,
  input wire logic         ep0_tx_done_flag_i,
  input wire logic         ep0_rx_done_flag_i,
  input wire logic         answer_valid_o,
  input wire uecc_answer_t answer_code_o,
  input wire logic [3:0]   answer_length_o,
  input wire logic         ep0_data_toggle_o,
  input wire logic         ep0_force_stall_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (reset_i);
  sequence s_stalled_tok;
    token_valid_i && ep0_force_stall_o &&
      token_kind_i inside {UECC_TOK_IN, UECC_TOK_OUT};
  endsequence
  sequence s_data_ans;
    answer_valid_o &&
      answer_code_o inside {UECC_ANS_DATA0, UECC_ANS_DATA1};
  endsequence
  property p_pid;
    s_data_ans |-> answer_code_o ==
      ($past(ep0_data_toggle_o) ? UECC_ANS_DATA1 : UECC_ANS_DATA0);
  endproperty
  a_pid: assert property (p_pid) else $error("wrong data pid");
  property p_hold;
    $changed(ep0_data_toggle_o) |-> $past(avs_write_i);
  endproperty
  a_hold: assert property (p_hold) else $error("toggle moved");
  property p_stall;
    s_stalled_tok |=> answer_valid_o && answer_code_o == UECC_ANS_STALL;
  endproperty
  a_stall: assert property (p_stall) else $error("no stall");
  property p_setup;
    token_valid_i && token_kind_i == UECC_TOK_SETUP |=> !ep0_force_stall_o;
  endproperty
  a_setup: assert property (p_setup) else $error("stall kept");
  property p_indata;
    s_data_ans |-> $past(token_kind_i) == UECC_TOK_IN &&
      !$past(ep0_force_stall_o);
  endproperty
  a_indata: assert property (p_indata) else $error("bad data");
  property p_take;
    answer_valid_o && answer_code_o == UECC_ANS_ACCEPT |->
      $past(token_kind_i) != UECC_TOK_IN;
  endproperty
  a_take: assert property (p_take) else $error("bad accept");
  property p_rst;
    $fell(reset_i) |-> !ep0_data_toggle_o && !ep0_force_stall_o;
  endproperty
  a_rst: assert property (p_rst) else $error("not cleared");
  property p_len;
    answer_valid_o && !(answer_code_o inside
      {UECC_ANS_DATA0, UECC_ANS_DATA1}) |-> answer_length_o == 4'h0;
  endproperty
  a_len: assert property (p_len) else $error("bad length");
  property p_nak_in;
    token_valid_i && token_kind_i == UECC_TOK_IN && !ep0_force_stall_o
      && ep0_tx_done_flag_i |=>
      answer_valid_o && answer_code_o == UECC_ANS_NAK;
  endproperty
  a_nak_in: assert property (p_nak_in) else $error("no in nak");
  property p_nak_out;
    token_valid_i && token_kind_i == UECC_TOK_OUT && !ep0_force_stall_o
      && ep0_rx_done_flag_i |=>
      answer_valid_o && answer_code_o == UECC_ANS_NAK;
  endproperty
  a_nak_out: assert property (p_nak_out) else $error("no out nak");
endmodule : uecc_properties
bind uecc_top uecc_properties uecc_properties_i (.*);

// file: test/uecc_host_model.sv
// Purpose: Host-controller model issuing endpoint-0 tokens
// Assumes: Tokens are one-cycle pulses on the device clock
// Notes:   Kind is inverted after release so no stale value lingers
`timescale 1ns/1ps
module uecc_host_model import uecc_pkg::*; (
  input  wire logic         mclk_i,
  input  wire logic         answer_valid_i,
  input  wire uecc_answer_t answer_code_i,
  input  wire logic [3:0]   answer_length_i,
  output      logic         token_valid_o,
  output      uecc_token_t  token_kind_o
);
  initial begin
    token_valid_o = 1'b0;
    token_kind_o  = UECC_TOK_SOF;
  end
  task automatic send(input uecc_token_t k, output logic [7:0] a);
    @(posedge mclk_i);
    token_valid_o <= 1'b1;
    token_kind_o  <= k;
    @(posedge mclk_i);
    token_valid_o <= 1'b0;
    token_kind_o  <= uecc_token_t'(~k);
    @(posedge mclk_i);
    a = {answer_valid_i, answer_code_i, answer_length_i};
  endtask : send
endmodule : uecc_host_model

// file: test/uecc_top_test.sv
// Purpose: Register and token scenarios for the endpoint-0 block
// Assumes: Avalon-MM master with bounded waits
// Notes:   Done flags are driven here in place of the status logic
`timescale 1ns/1ps
module uecc_top_test;
  import uecc_pkg::*;
  logic         mclk_i = 1'b0;
  logic         reset_i = 1'b1;
  logic [11:0]  adr = 12'h0;
  logic         rd = 1'b0;
  logic         wr = 1'b0;
  logic [31:0]  wdat = 32'h0;
  logic [31:0]  rdat, rv;
  logic [3:0]   be = 4'h1;
  logic         txd = 1'b0;
  logic         rxd = 1'b0;
  logic         tok_v, ans_v, wreq;
  uecc_token_t  tok_k;
  uecc_answer_t ans_c;
  logic [3:0]   ans_l;
  logic [7:0]   av;
  int           mismatches = 0;
  int           samples_checked = 0;
  always #2 mclk_i = ~mclk_i;
  uecc_top uecc_top_i (.mclk_i(mclk_i), .reset_i(reset_i),
    .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
    .avs_writedata_i(wdat), .avs_byteenable_i(be),
    .avs_readdata_o(rdat), .avs_waitrequest_o(wreq), .avs_response_o(),
    .token_valid_i(tok_v), .token_kind_i(tok_k),
    .ep0_tx_done_flag_i(txd), .ep0_rx_done_flag_i(rxd),
    .answer_valid_o(ans_v), .answer_code_o(ans_c),
    .answer_length_o(ans_l), .ep0_data_toggle_o(), .ep0_force_stall_o());
  uecc_host_model uecc_host_model_i (.mclk_i(mclk_i),
    .answer_valid_i(ans_v), .answer_code_i(ans_c),
    .answer_length_i(ans_l), .token_valid_o(tok_v), .token_kind_o(tok_k));
  task automatic tally_and_finish;
    if (mismatches == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : tally_and_finish
  task automatic bus(input logic w, input logic [11:0] a,
                     input logic [31:0] d, input logic [3:0] b);
    int n;
    @(posedge mclk_i);
    rd <= !w;
    wr <= w;
    adr <= a;
    wdat <= d;
    be <= b;
    n = 0;
    do begin
      @(posedge mclk_i);
      n++;
    end while (wreq !== 1'b0 && n < 20);
    if (wreq !== 1'b0) begin
      mismatches++;
      tally_and_finish();
    end
    rv = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus
  task automatic wrc(input logic [7:0] d);
    bus(1'b1, EP0_CTRL_ADDR, {24'h0, d}, 4'h1);
  endtask : wrc
  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0, 4'h1);
    samples_checked++;
    if (rv !== e) begin
      mismatches++;
      $display("[ERR] %0t got %h exp %h", $time, rv, e);
    end
  endtask : rdc
  task automatic tk(input uecc_token_t k, input logic [7:0] e);
    uecc_host_model_i.send(k, av);
    samples_checked++;
    if (av !== e) begin
      mismatches++;
      $display("[ERR] %0t got %h exp %h", $time, av, e);
    end
  endtask : tk
  task automatic flags(input logic t, input logic r);
    @(posedge mclk_i);
    txd <= t;
    rxd <= r;
  endtask : flags
  initial begin
    repeat (6) @(posedge mclk_i);
    reset_i <= 1'b0;
    rdc(EP0_CTRL_ADDR, 32'h0);
    rdc(12'h3b4, 32'h0);
    wrc(8'h2f);
    tk(UECC_TOK_IN, {1'b1, UECC_ANS_DATA0, 4'hf});
    tk(UECC_TOK_IN, {1'b1, UECC_ANS_DATA0, 4'hf});
    rdc(EP0_CTRL_ADDR, 32'h2f);
    wrc(8'ha0);
    tk(UECC_TOK_IN, {1'b1, UECC_ANS_DATA1, 4'h0});
    flags(1'b1, 1'b0);
    rdc(EP0_STAT_ADDR, 32'h1);
    tk(UECC_TOK_IN, {1'b1, UECC_ANS_NAK, 4'h0});
    flags(1'b0, 1'b0);
    wrc(8'h93);
    tk(UECC_TOK_IN, {1'b1, UECC_ANS_NAK, 4'h0});
    tk(UECC_TOK_OUT, {1'b1, UECC_ANS_ACCEPT, 4'h0});
    flags(1'b0, 1'b1);
    rdc(EP0_STAT_ADDR, 32'h2);
    tk(UECC_TOK_OUT, {1'b1, UECC_ANS_NAK, 4'h0});
    flags(1'b0, 1'b0);
    wrc(8'h83);
    tk(UECC_TOK_OUT, {1'b1, UECC_ANS_NAK, 4'h0});
    tk(UECC_TOK_SOF, 8'h00);
    rdc(EP0_EVT_ADDR, 32'h0);
    wrc(8'h75);
    tk(UECC_TOK_IN, {1'b1, UECC_ANS_STALL, 4'h0});
    tk(UECC_TOK_OUT, {1'b1, UECC_ANS_STALL, 4'h0});
    uecc_host_model_i.send(UECC_TOK_SETUP, av);
    rdc(EP0_CTRL_ADDR, 32'h35);
    rdc(EP0_EVT_ADDR, 32'h3);
    bus(1'b1, EP0_EVT_ADDR, 32'h3, 4'h1);
    rdc(EP0_EVT_ADDR, 32'h0);
    bus(1'b1, EP0_CTRL_ADDR, 32'hff, 4'h0);
    rdc(EP0_CTRL_ADDR, 32'h35);
    tk(UECC_TOK_IN, {1'b1, UECC_ANS_DATA0, 4'h5});
    @(posedge mclk_i);
    reset_i <= 1'b1;
    repeat (2) @(posedge mclk_i);
    reset_i <= 1'b0;
    rdc(EP0_CTRL_ADDR, 32'h0);
    tk(UECC_TOK_IN, {1'b1, UECC_ANS_NAK, 4'h0});
    tally_and_finish();
  end
endmodule : uecc_top_test
